// ### gated_pulse_train_counter.sv
/*
 * Gated pulse train counter with APB registers: continuous
 * two-phase pulse train or frequency divider, gated by an
 * external pin, counting a 10 MHz timebase or a source pin.
 * Assumes an APB master on pclk and TTL level pins.
 */
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps

// Function
// - Gate setting 0 ignores gate; counting starts at software start.
// - Setting 1 counts while gate high, setting 2 while gate low.
// - Setting 3 starts on gate rising edge, setting 4 on falling.
// - Edge gate settings give one complete pulse per qualifying edge; further edges while one is already queued are dropped.
// - Polarity 0: output low in phase one, high in phase two.
// - Polarity 1: output high in phase one, low in phase two.
// - Duty is phase two over period; default is one half.
// - Period at least three ticks; duty 0 or 1 gets nearest split.
// - Pulse train timebase 0 or 10000000 picks internal 10 MHz, else source pin.
// - Divider output frequency is input frequency over divisor; divisor 0 or 1 divides by two.
// - Divider timebase at or below zero counts source pin edges.
module gated_pulse_train_counter (
	input  wire logic        pclk,        // 40 MHz clock
	input  wire logic        presetn,     // async reset, low
	input  wire logic        psel,        // APB select
	input  wire logic        penable,     // APB enable
	input  wire logic        pwrite,      // APB write
	input  wire logic [7:0]  paddr,       // APB byte address
	input  wire logic [31:0] pwdata,      // APB write data
	output logic      [31:0] prdata,      // APB read data
	output logic             pready,      // APB ready
	output logic             pslverr,     // APB error
	input  wire logic        counter_gate_input,   // gate pin
	input  wire logic        counter_source_input, // source pin
	output logic             counter_pulse_output, // pulse train
	output logic             divider_output        // divided clock
);
	logic [counter_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
	logic [31:0] tb_r, tb_nxt;
	logic [31:0] ph1_r, ph1_nxt;
	logic [31:0] ph2_r, ph2_nxt;
	logic [31:0] div_r, div_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic        err_r, err_nxt;
	logic        pend_r, pend_nxt;
	logic        pout_r, pout_nxt;
	logic        dout_r, dout_nxt;

	logic        run, div_mode, pol;
	logic [2:0]  gmode;
	logic        edge_mode, edge_hit, hold;
	logic        int_sel, tick;
	logic        phase2, busy, taken, trig;
	logic [31:0] len1, len2, e1, e2;
	logic        wr, setup, known;

	pin_if pins ();

	pin_conditioner u_cond (
		.pclk    (pclk),
		.presetn (presetn),
		.gate_pin(counter_gate_input),
		.src_pin (counter_source_input),
		.pins    (pins.drive)
	);

	assign run      = ctrl_r[counter_pkg::CTRL_RUN];
	assign div_mode = ctrl_r[counter_pkg::CTRL_DIV];
	assign pol      = ctrl_r[counter_pkg::CTRL_POL];
	assign gmode    = ctrl_r[counter_pkg::CTRL_GM +: 3];

	// Timebase selection differs by operation
	always_comb begin
		if (div_mode)
			int_sel = ($signed(tb_r) > 0);
		else
			int_sel = (tb_r == 32'h0000_0000) ||
				(tb_r == counter_pkg::TB_INT);
		tick = int_sel ? pins.tb_tick : pins.src_rise;
	end

	// Gate qualification
	always_comb begin
		edge_mode = 1'b0;
		edge_hit  = 1'b0;
		hold      = 1'b0;
		case (gmode)
			counter_pkg::GM_SOFT: hold = 1'b0;
			counter_pkg::GM_HIGH: hold = ~pins.gate_lvl;
			counter_pkg::GM_LOW:  hold = pins.gate_lvl;
			counter_pkg::GM_RISE: begin
				edge_mode = 1'b1;
				edge_hit  = pins.gate_rise;
			end
			counter_pkg::GM_FALL: begin
				edge_mode = 1'b1;
				edge_hit  = pins.gate_fall;
			end
			default: hold = 1'b0;
		endcase
	end

	// Pending edge: an edge during a pulse queues the next one
	always_comb begin
		pend_nxt = pend_r;
		if (taken)
			pend_nxt = 1'b0;
		if (edge_hit)
			pend_nxt = 1'b1;
		if (!run || !edge_mode)
			pend_nxt = 1'b0;
	end

	assign trig = edge_mode ? pend_r : 1'b1;

	// Effective phase lengths; pulse train period never under the minimum
	always_comb begin
		e1 = (ph1_r == 32'h0) ? 32'h1 : ph1_r;
		e2 = (ph2_r == 32'h0) ? 32'h1 : ph2_r;
		// Sum kept one bit wider so huge lengths cannot wrap
		if ({1'b0, e1} + {1'b0, e2} <
			33'(counter_pkg::MIN_PER)) begin
			if (ph2_r == 32'h0)
				e1 = 32'(counter_pkg::MIN_PER) - e2;
			else
				e2 = 32'(counter_pkg::MIN_PER) - e1;
		end
		if (div_mode) begin
			// Divisor below two cannot form a pulse
			len2 = 32'h1;
			len1 = (div_r < 32'h2) ? 32'h1 : div_r - 32'h1;
		end else begin
			len1 = e1;
			len2 = e2;
		end
	end

	phase_engine #(.W(32)) u_eng (
		.pclk    (pclk),
		.presetn (presetn),
		.tick    (tick),
		.enable  (run),
		.one_shot(edge_mode),
		.trig    (trig),
		.hold    (hold),
		.len1    (len1),
		.len2    (len2),
		.phase2  (phase2),
		.busy    (busy),
		.taken   (taken)
	);

	// Outputs registered; idle shows the phase one level
	always_comb begin
		pout_nxt = pol;
		dout_nxt = 1'b0;
		if (div_mode)
			dout_nxt = phase2;
		else
			pout_nxt = phase2 ^ pol;
	end

	// APB slave: zero wait, data prepared in setup cycle
	assign pready = 1'b1;
	assign setup  = psel & ~penable;
	assign wr     = psel & penable & pwrite;

	always_comb begin
		case (paddr)
			counter_pkg::OFS_CTRL,
			counter_pkg::OFS_TB,
			counter_pkg::OFS_PH1,
			counter_pkg::OFS_PH2,
			counter_pkg::OFS_DIV,
			counter_pkg::OFS_STAT: known = 1'b1;
			default:               known = 1'b0;
		endcase
	end

	always_comb begin
		rd_nxt  = rd_r;
		err_nxt = err_r;
		if (setup) begin
			err_nxt = ~known;
			rd_nxt  = 32'h0;
			if (!pwrite) begin
				case (paddr)
					counter_pkg::OFS_CTRL:
						rd_nxt = 32'(ctrl_r);
					counter_pkg::OFS_TB:  rd_nxt = tb_r;
					counter_pkg::OFS_PH1: rd_nxt = ph1_r;
					counter_pkg::OFS_PH2: rd_nxt = ph2_r;
					counter_pkg::OFS_DIV: rd_nxt = div_r;
					counter_pkg::OFS_STAT:
						rd_nxt = {28'h0, int_sel, pend_r,
							phase2, busy};
					default: rd_nxt = 32'h0;
				endcase
			end
		end
	end

	// Status register is read only
	always_comb begin
		ctrl_nxt = ctrl_r;
		tb_nxt   = tb_r;
		ph1_nxt  = ph1_r;
		ph2_nxt  = ph2_r;
		div_nxt  = div_r;
		if (wr) begin
			case (paddr)
				counter_pkg::OFS_CTRL: ctrl_nxt =
					pwdata[counter_pkg::CTRL_W-1:0];
				counter_pkg::OFS_TB:  tb_nxt  = pwdata;
				counter_pkg::OFS_PH1: ph1_nxt = pwdata;
				counter_pkg::OFS_PH2: ph2_nxt = pwdata;
				counter_pkg::OFS_DIV: div_nxt = pwdata;
				default: ctrl_nxt = ctrl_r;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= counter_pkg::CTRL_RST;
			tb_r   <= counter_pkg::TB_RST;
			ph1_r  <= counter_pkg::PH_RST;
			ph2_r  <= counter_pkg::PH_RST;
			div_r  <= counter_pkg::DIV_RST;
			rd_r   <= 32'h0;
			err_r  <= 1'b0;
			pend_r <= 1'b0;
			pout_r <= 1'b0;
			dout_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			tb_r   <= tb_nxt;
			ph1_r  <= ph1_nxt;
			ph2_r  <= ph2_nxt;
			div_r  <= div_nxt;
			rd_r   <= rd_nxt;
			err_r  <= err_nxt;
			pend_r <= pend_nxt;
			pout_r <= pout_nxt;
			dout_r <= dout_nxt;
		end
	end

	assign prdata  = rd_r;
	assign pslverr = penable & err_r;
	assign counter_pulse_output = pout_r;
	assign divider_output       = dout_r;
endmodule : gated_pulse_train_counter

// ### counter_pkg.sv
/*
 * Shared constants of the gated pulse train counter.
 * Assumes a 40 MHz pclk and 32-bit APB data.
 */
package counter_pkg;
	localparam int          CLK_HZ   = 40_000_000;
	localparam int          TB_HZ    = 10_000_000;
	localparam int          TB_DIV   = CLK_HZ / TB_HZ;
	localparam logic [31:0] TB_INT   = 32'h0098_9680;
	localparam int          MIN_PER  = 3;

	localparam logic [7:0]  OFS_CTRL = 8'h00;
	localparam logic [7:0]  OFS_TB   = 8'h04;
	localparam logic [7:0]  OFS_PH1  = 8'h08;
	localparam logic [7:0]  OFS_PH2  = 8'h0C;
	localparam logic [7:0]  OFS_DIV  = 8'h10;
	localparam logic [7:0]  OFS_STAT = 8'h14;

	localparam int          CTRL_RUN = 0;
	localparam int          CTRL_DIV = 1;
	localparam int          CTRL_GM  = 2;
	localparam int          CTRL_POL = 5;
	localparam int          CTRL_W   = 6;

	localparam logic [2:0]  GM_SOFT  = 3'h0;
	localparam logic [2:0]  GM_HIGH  = 3'h1;
	localparam logic [2:0]  GM_LOW   = 3'h2;
	localparam logic [2:0]  GM_RISE  = 3'h3;
	localparam logic [2:0]  GM_FALL  = 3'h4;

	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
	localparam logic [31:0] TB_RST   = 32'h0000_0000;
	localparam logic [31:0] PH_RST   = 32'h0000_0005;
	localparam logic [31:0] DIV_RST  = 32'h0000_0002;
endpackage : counter_pkg

// ### pin_if.sv
/*
 * Conditioned pin events and timebase tick, from the
 * input conditioner to the counter top.
 * Assumes one pclk domain on both sides.
 */
`timescale 1ns/1ps
interface pin_if;
	logic tb_tick;
	logic src_rise;
	logic gate_lvl;
	logic gate_rise;
	logic gate_fall;
	modport drive (output tb_tick, src_rise, gate_lvl,
		gate_rise, gate_fall);
	modport use_side (input tb_tick, src_rise, gate_lvl,
		gate_rise, gate_fall);
endinterface : pin_if

// ### pin_conditioner.sv
/*
 * Two-flop synchronisers for gate and source pins, edge
 * detection, and the 10 MHz timebase enable divider.
 * Assumes the pins are asynchronous TTL levels.
 */
`timescale 1ns/1ps
module pin_conditioner (
	input  wire logic pclk,          // 40 MHz clock
	input  wire logic presetn,       // async reset, low
	input  wire logic gate_pin,      // raw gate pin
	input  wire logic src_pin,       // raw source pin
	pin_if.drive      pins           // conditioned events
);
	localparam int DW = $clog2(counter_pkg::TB_DIV);

	logic [1:0]    s1_r, s2_r, s3_r;
	logic [1:0]    s1_nxt, s2_nxt, s3_nxt;
	logic [DW-1:0] div_r, div_nxt;
	logic [1:0]    arm_r, arm_nxt;
	logic          armed;

	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_sync
			always_comb begin
				s1_nxt[i] = (i == 0) ? gate_pin : src_pin;
				s2_nxt[i] = s1_r[i];
				s3_nxt[i] = s2_r[i];
			end
		end
	endgenerate

	always_comb begin
		if (div_r == DW'(counter_pkg::TB_DIV - 1))
			div_nxt = '0;
		else
			div_nxt = div_r + DW'(1);
		arm_nxt = armed ? arm_r : arm_r + 2'h1;
	end

	// Edges masked until the third stage holds a real sample;
	// a pin high at reset would otherwise look like an edge
	assign armed = (arm_r == 2'h3);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r  <= 2'h0;
			s2_r  <= 2'h0;
			s3_r  <= 2'h0;
			div_r <= '0;
			arm_r <= 2'h0;
		end else begin
			s1_r  <= s1_nxt;
			s2_r  <= s2_nxt;
			s3_r  <= s3_nxt;
			div_r <= div_nxt;
			arm_r <= arm_nxt;
		end
	end

	assign pins.tb_tick   = (div_r == DW'(counter_pkg::TB_DIV - 1));
	assign pins.gate_lvl  = s2_r[0];
	assign pins.gate_rise = armed & s2_r[0] & ~s3_r[0];
	assign pins.gate_fall = armed & ~s2_r[0] & s3_r[0];
	assign pins.src_rise  = armed & s2_r[1] & ~s3_r[1];
endmodule : pin_conditioner

// ### phase_engine.sv
/*
 * Two-phase down counter: phase one, then phase two,
 * reloading lengths at each phase entry.
 * Assumes lengths of at least one tick.
 */
`timescale 1ns/1ps
module phase_engine #(
	parameter int W = 32
) (
	input  wire logic         pclk,     // 40 MHz clock
	input  wire logic         presetn,  // async reset, low
	input  wire logic         tick,     // count enable pulse
	input  wire logic         enable,   // counter running
	input  wire logic         one_shot, // stop after phase two
	input  wire logic         trig,     // start from idle
	input  wire logic         hold,     // gate pauses counting
	input  wire logic [W-1:0] len1,     // phase one ticks
	input  wire logic [W-1:0] len2,     // phase two ticks
	output logic              phase2,   // in phase two
	output logic              busy,     // pulse in progress
	output logic              taken     // trig accepted
);
	typedef enum logic [1:0] {ST_IDLE, ST_P1, ST_P2} state_type;

	generate
		if (W < 2) begin : g_chk
			$error("phase_engine: W must be at least 2");
		end
	endgenerate

	state_type      st_r, st_nxt;
	logic [W-1:0]   cnt_r, cnt_nxt;
	logic           adv;

	assign adv = tick & ~hold;

	always_comb begin
		st_nxt  = st_r;
		cnt_nxt = cnt_r;
		taken   = 1'b0;
		if (!enable) begin
			st_nxt = ST_IDLE;
		end else begin
			case (st_r)
				ST_IDLE: if (trig) begin
					taken   = 1'b1;
					st_nxt  = ST_P1;
					cnt_nxt = len1;
				end
				ST_P1: if (adv) begin
					if (cnt_r <= W'(1)) begin
						st_nxt  = ST_P2;
						cnt_nxt = len2;
					end else begin
						cnt_nxt = cnt_r - W'(1);
					end
				end
				ST_P2: if (adv) begin
					if (cnt_r > W'(1)) begin
						cnt_nxt = cnt_r - W'(1);
					end else if (one_shot) begin
						st_nxt = ST_IDLE;
					end else begin
						st_nxt  = ST_P1;
						cnt_nxt = len1;
					end
				end
				default: st_nxt = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r  <= ST_IDLE;
			cnt_r <= '0;
		end else begin
			st_r  <= st_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign phase2 = (st_r == ST_P2);
	assign busy   = (st_r != ST_IDLE);
endmodule : phase_engine

// ### gated_pulse_train_counter_checker.sv
/* Port assertions for the pulse train counter.
   Assumes one pclk domain; snoops CTRL writes on APB. */
`timescale 1ns/1ps
module counter_port_checker (
	input wire logic        pclk,                 // clock
	input wire logic        presetn,              // reset, low
	input wire logic        psel,                 // select
	input wire logic        penable,              // enable
	input wire logic        pwrite,               // write
	input wire logic [7:0]  paddr,                // address
	input wire logic [31:0] pwdata,               // write data
	input wire logic [31:0] prdata,               // read data
	input wire logic        pready,               // ready
	input wire logic        pslverr,              // error
	input wire logic        counter_gate_input,   // gate pin
	input wire logic        counter_pulse_output, // pulse
	input wire logic        divider_output        // divided
);
	logic [5:0] ctrl_r;
	logic [5:0] ctrl_nxt;
	logic       bad_a;
	assign bad_a = paddr[1:0] != 2'h0 || paddr > counter_pkg::OFS_STAT;
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (psel && penable && pwrite && paddr == counter_pkg::OFS_CTRL)
			ctrl_nxt = pwdata[5:0];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_r <= 6'h00;
		else
			ctrl_r <= ctrl_nxt;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_acc;
		psel && penable;
	endsequence
	// Gate level that pauses counting; sync delay covered by 8
	sequence s_hold;
		ctrl_r[1:0] == 2'h1 && $stable(ctrl_r) &&
		(ctrl_r[4:2] == counter_pkg::GM_HIGH && !counter_gate_input ||
		ctrl_r[4:2] == counter_pkg::GM_LOW && counter_gate_input);
	endsequence
	chk_ready_high: assert property (pready)
		else $error("pready low");
	chk_unmapped_err: assert property (s_acc ##0 (bad_a && !pwrite)
		|-> pslverr && prdata == 32'h0) else $error("unmapped read");
	chk_mapped_ok: assert property (s_acc ##0 !bad_a |-> !pslverr)
		else $error("error on mapped address");
	chk_err_idle: assert property (!penable |-> !pslverr)
		else $error("error outside access");
	chk_read_holds: assert property (s_acc |=> $stable(prdata))
		else $error("read data moved");
	chk_idle_level: assert property (
		(!ctrl_r[0] && $stable(ctrl_r))[*3]
		|-> counter_pulse_output == ctrl_r[5]) else $error("idle level");
	chk_gate_hold: assert property (
		s_hold[*8] |-> $stable(counter_pulse_output))
		else $error("counted while gated off");
	chk_div_run: assert property (
		$rose(divider_output) |-> $past(ctrl_r[1:0], 2) == 2'h3)
		else $error("divider pulse while off");
endmodule : counter_port_checker

bind gated_pulse_train_counter counter_port_checker chk_u (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.counter_gate_input, .counter_pulse_output, .divider_output);

// ### pin_source_model.sv
/* Far-side TTL pins: free-running source clock, gate level
   as commanded. Assumes pins unrelated to pclk. */
`timescale 1ns/1ps
module pin_source_model #(
	parameter int HALF_NS = 37 // source half period
) (
	input  wire logic gate_cmd, // wanted gate level
	output wire logic gate_pin, // gate pin
	output logic      src_pin   // source pin
);
	// Small skew keeps gate edges off pclk edges
	assign #3 gate_pin = gate_cmd;
	initial begin
		src_pin = 1'b0;
		forever #HALF_NS src_pin = !src_pin;
	end
endmodule : pin_source_model

// ### gated_pulse_train_counter_tb_top.sv
/* Self-checking bench: registers, pulse timing, gate modes,
   divider. Assumes the pin model drives gate and source. */
`timescale 1ns/1ps
module gated_pulse_train_counter_tb_top;
	logic        pclk, presetn, psel, penable, pwrite, er, gate_cmd, sel;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, seed, v;
	logic [31:0] mreg [5];
	wire         pready, pslverr, gate, src, pout, dout;
	int          mismatches, n_tests, p1, p2, d, len, c;

	gated_pulse_train_counter dut_u (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.counter_gate_input(gate), .counter_source_input(src),
		.counter_pulse_output(pout), .divider_output(dout));
	pin_source_model #(.HALF_NS(37)) far_u (.gate_cmd, .gate_pin(gate),
		.src_pin(src));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = !pclk;
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	// Source ticks from a pclk count, 74 ns source period
	function automatic int tk(int n);
		return (n * 25 + 37) / 74;
	endfunction : tk

	task automatic final_report;
		if (mismatches == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report

	task automatic fail;
		mismatches++;
		final_report();
	endtask : fail

	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic apb(logic wr, logic [7:0] a, logic [31:0] dat);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= dat;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20)
			fail();
		if (wr && a < 8'h14)
			mreg[a[4:2]] = a == 8'h00 ? dat & 32'h3F : dat;
	endtask : apb

	// Length of the next whole run of level lvl
	task automatic meas(bit dv, logic lvl, output int n);
		int k;
		k = 0;
		n = 0;
		// Outputs are sampled mid-cycle, where they are settled
		while ((dv ? dout : pout) === lvl && k < 3000) begin
			@(negedge pclk);
			k++;
		end
		while ((dv ? dout : pout) !== lvl && k < 3000) begin
			@(negedge pclk);
			k++;
		end
		while ((dv ? dout : pout) === lvl && k < 3000) begin
			@(negedge pclk);
			k++;
			n++;
		end
		if (k >= 3000)
			fail();
	endtask : meas

	task automatic chg(int cyc, output int n);
		logic last;
		n = 0;
		last = pout;
		repeat (cyc) begin
			@(negedge pclk);
			if (pout !== last)
				n++;
			last = pout;
		end
	endtask : chg

	initial begin
		{psel, penable, pwrite, gate_cmd} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		seed = 32'd69716;
		mismatches = 0;
		n_tests = 0;
		mreg = '{32'h0, counter_pkg::TB_RST, counter_pkg::PH_RST,
			counter_pkg::PH_RST, counter_pkg::DIV_RST};
		presetn = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			// Second pass writes first, so the read proves the write
			if (i > 4)
				apb(1, 8'(i % 5 * 4), i == 5 ? xs() & 32'hFFE : xs());
			apb(0, 8'(i % 5 * 4), 32'h0);
			check("reg", rd, mreg[i % 5]);
			check("reg err", 32'(er), 32'h0);
		end
		// Stopped counter: only the timebase source bit may be set
		sel = mreg[0][1] ? $signed(mreg[1]) > 0 :
			mreg[1] == 32'h0 || mreg[1] == counter_pkg::TB_INT;
		apb(0, counter_pkg::OFS_STAT, 32'h0);
		check("status", rd, {28'h0, sel, 3'h0});
		apb(0, 8'h40, 32'h0);
		check("unmapped", rd, 32'h0);
		check("unmapped err", 32'(er), 32'h1);
		for (int t = 0; t < 4; t++) begin
			p1 = 2 + xs() % 6;
			p2 = 1 + xs() % 6;
			v = t < 2 ? (t ? counter_pkg::TB_INT : 32'h0) : 32'h5;
			apb(1, counter_pkg::OFS_PH1, p1);
			apb(1, counter_pkg::OFS_PH2, p2);
			apb(1, counter_pkg::OFS_TB, v);
			apb(1, counter_pkg::OFS_CTRL, {t[0], 5'h01});
			meas(0, !t[0], len);
			check("phase2", t > 1 ? tk(len) : len, t > 1 ? p2 : p2 * 4);
			meas(0, t[0], len);
			check("phase1", t > 1 ? tk(len) : len, t > 1 ? p1 : p1 * 4);
			apb(1, counter_pkg::OFS_CTRL, 32'h0);
		end
		apb(1, counter_pkg::OFS_TB, 32'h0);
		// Zero phase two: one tick, phase one stretched to fill three
		apb(1, counter_pkg::OFS_PH1, 32'h1);
		apb(1, counter_pkg::OFS_PH2, 32'h0);
		apb(1, counter_pkg::OFS_CTRL, 32'h1);
		meas(0, 1'b1, len);
		check("min phase2", len, 4);
		meas(0, 1'b0, len);
		check("min phase1", len, 8);
		apb(1, counter_pkg::OFS_CTRL, 32'h0);
		apb(1, counter_pkg::OFS_PH1, p1);
		apb(1, counter_pkg::OFS_PH2, p2);
		for (int g = 1; g < 5; g++) begin
			gate_cmd <= !g[0];
			apb(1, counter_pkg::OFS_CTRL, {g[2:0], 2'h1});
			chg(80, c);
			check("held", c, 0);
			gate_cmd <= g[0];
			if (g < 3) begin
				meas(0, 1'b1, len);
				check("gated", len, p2 * 4);
			end else begin
				chg(200, c);
				check("one shot", c, 2);
			end
			apb(1, counter_pkg::OFS_CTRL, 32'h0);
		end
		d = 2 + xs() % 6;
		apb(1, counter_pkg::OFS_DIV, d);
		for (int t = 0; t < 2; t++) begin
			apb(1, counter_pkg::OFS_TB, t ? 32'h0 : counter_pkg::TB_INT);
			apb(1, counter_pkg::OFS_CTRL, 32'h3);
			meas(1, 1'b0, len);
			check("divider", t ? tk(len) : len, t ? d - 1 : d * 4 - 4);
			apb(1, counter_pkg::OFS_CTRL, 32'h0);
		end
		final_report();
	end
endmodule : gated_pulse_train_counter_tb_top
